/* File: rtl/isb_byte_mem.sv */
/*
 * isb_byte_mem: small byte memory holding burst data for one transfer.
 * assumes one writer and one reader in the same clock domain.
 */
`timescale 1ns/1ps
module isb_byte_mem import isb_pkg::*;
(
	// clock only
	input  wire logic       i_clock,
	// write side
	input  wire logic       i_we,
	input  wire logic [2:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	// read side
	input  wire logic [2:0] i_raddr,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem_q [MAX_BYTES];

	always_ff @(posedge i_clock)
	begin
		if (i_we)
			mem_q[i_waddr] <= i_wdata;
		o_rdata <= mem_q[i_raddr];
	end
endmodule : isb_byte_mem

/* File: rtl/isb_master.sv */
/*
 * isb_master: byte-level i2c master for the accelerometer and the switched bus,
 * plus the bus-ownership select bit held in a direction/data register pair.
 * assumes open-drain scl/sda with pull-ups; no clock stretching by slaves.
 */
`timescale 1ns/1ps
module isb_master import isb_pkg::*;
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	// command
	input  wire logic       i_start,
	input  isb_req_t        i_req,
	input  wire logic       i_take_bus,
	input  wire logic       i_release_bus,
	// write data load
	input  wire logic       i_wr_we,
	input  wire logic [2:0] i_wr_addr,
	input  wire logic [7:0] i_wr_data,
	// read data
	input  wire logic [2:0] i_rd_addr,
	output logic      [7:0] o_rd_data,
	// status
	output logic            o_busy,
	output logic            o_done,
	output logic            o_nack,
	output logic            o_bus_owned,
	output logic      [7:0] o_status,
	// i2c pins, oe high pulls line low
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_scl_out,
	output logic            o_scl_oe,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	// select pin
	output logic            o_bus_sel
);
	typedef enum logic [3:0]
	{
		ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_RSTART, ST_STOP, ST_DONE
	} isb_state_t;

	typedef enum logic [1:0] { PH_ADDRW, PH_INDEX, PH_ADDRR, PH_DATA } isb_phase_t;

	typedef struct packed
	{
		isb_state_t  st;
		isb_phase_t  ph;
		isb_req_t    req;
		logic [7:0]  cnt;
		logic [1:0]  qtr;
		logic [2:0]  bitn;
		logic [7:0]  sh;
		logic [3:0]  nbyte;
		logic        rd;
		isb_pins_t   pins;
		logic        done;
		logic        nack;
		logic [31:0] dir;
		logic [31:0] dat;
		logic        pend_sel;
		logic        mem_we;
		logic [7:0]  mem_wd;
	} isb_state_s_t;

	isb_state_s_t s_q, s_d;
	logic [7:0]   mem_rd;
	logic [2:0]   mem_ra;
	logic         tick;
	logic         sec_ok;

	// registered read: during a frame keep the next outgoing slot addressed, ack phases too
	assign mem_ra = s_q.st != ST_IDLE ? s_q.nbyte[2:0] : i_rd_addr;

	isb_byte_mem u_mem
	(
		.i_clock (i_clock),
		.i_we    (s_q.mem_we | i_wr_we),
		.i_waddr (s_q.mem_we ? s_q.nbyte[2:0] - 3'h1 : i_wr_addr),
		.i_wdata (s_q.mem_we ? s_q.mem_wd : i_wr_data),
		.i_raddr (mem_ra),
		.o_rdata (mem_rd)
	);

	assign tick   = s_q.cnt == 8'(QTR_CYC - 1);
	assign sec_ok = s_q.dir[SEL_BIT] & s_q.dat[SEL_BIT] & ~s_q.pend_sel;

	always_comb
	begin
		s_d        = s_q;
		s_d.done   = 1'b0;
		s_d.mem_we = 1'b0;
		s_d.cnt    = tick ? 8'h00 : s_q.cnt + 8'h01;
		// direction first, data one cycle later
		if (s_q.pend_sel)
		begin
			s_d.dat[SEL_BIT] = 1'b1;
			s_d.pend_sel     = 1'b0;
		end
		if (i_take_bus && s_q.st == ST_IDLE)
		begin
			s_d.dir      = s_q.dir | SEL_MASK;
			s_d.pend_sel = 1'b1;
		end
		if (i_release_bus && s_q.st == ST_IDLE)
			s_d.dat = s_q.dat & ~SEL_MASK;
		unique case (s_q.st)
			ST_IDLE:
			begin
				s_d.cnt = 8'h00;
				s_d.qtr = 2'h0;
				if (i_start && !i_take_bus && !i_release_bus && (!i_req.sec_bus || sec_ok))
				begin
					s_d.req = i_req;
					if (i_req.op == ISB_OP_FMT)
					begin
						s_d.req.index = ACCEL_FMT_IDX;
						s_d.req.count = 4'h1;
					end
					if (i_req.op == ISB_OP_AXES)
					begin
						s_d.req.index = ACCEL_XLO_IDX;
						s_d.req.count = 4'(AXIS_BYTES);
					end
					s_d.req.sec_bus = i_req.sec_bus & (i_req.op inside {ISB_OP_WRITE, ISB_OP_READ});
					s_d.ph    = PH_ADDRW;
					s_d.nbyte = 4'h0;
					s_d.nack  = 1'b0;
					s_d.rd    = 1'b0;
					s_d.st    = ST_START;
				end
			end
			ST_START, ST_RSTART:
			begin
				if (tick)
				begin
					s_d.qtr = s_q.qtr + 2'h1;
					unique case (s_q.qtr)
						2'h0: s_d.pins = '{scl_oe: 1'b0, sda_oe: 1'b0};
						2'h1: s_d.pins.sda_oe = 1'b1;
						2'h2: s_d.pins.scl_oe = 1'b1;
						2'h3:
						begin
							// address byte, r/w in bit 0
							s_d.sh   = {(s_q.req.sec_bus ? VDEC_ADDR : ACCEL_ADDR), s_q.st == ST_RSTART};
							s_d.ph   = s_q.st == ST_RSTART ? PH_ADDRR : PH_ADDRW;
							s_d.rd   = 1'b0;
							s_d.bitn = 3'h7;
							s_d.st   = ST_BIT;
						end
					endcase
				end
			end
			ST_BIT, ST_ACK:
			begin
				if (tick)
				begin
					s_d.qtr = s_q.qtr + 2'h1;
					unique case (s_q.qtr)
						2'h0:
						begin
							if (s_q.st == ST_BIT)
								s_d.pins.sda_oe = s_q.rd ? 1'b0 : ~s_q.sh[7];
							else
								s_d.pins.sda_oe = s_q.rd && s_q.nbyte != {4'h0 | s_q.req.count};
						end
						2'h1: s_d.pins.scl_oe = 1'b0;
						2'h2:
						begin
							if (s_q.st == ST_BIT)
								s_d.sh = {s_q.sh[6:0], i_sda};
							else if (!s_q.rd && i_sda)
								s_d.nack = 1'b1;
						end
						2'h3:
						begin
							s_d.pins.scl_oe = 1'b1;
							if (s_q.st == ST_BIT)
							begin
								s_d.bitn = s_q.bitn - 3'h1;
								if (s_q.bitn == 3'h0)
								begin
									s_d.st = ST_ACK;
									if (s_q.rd)
									begin
										s_d.mem_we = 1'b1;
										s_d.mem_wd = s_q.sh;
										s_d.nbyte  = s_q.nbyte + 4'h1;
									end
								end
							end
							else if (s_q.nack)
								s_d.st = ST_STOP;
							else
							begin
								s_d.bitn = 3'h7;
								s_d.st   = ST_BIT;
								unique case (s_q.ph)
									PH_ADDRW:
									begin
										s_d.sh = s_q.req.index;
										s_d.ph = PH_INDEX;
									end
									PH_INDEX:
									begin
										if (s_q.req.op inside {ISB_OP_READ, ISB_OP_AXES})
											s_d.st = ST_RSTART;
										else
										begin
											s_d.sh    = s_q.req.op == ISB_OP_FMT ? ACCEL_FMT_VAL : mem_rd;
											s_d.nbyte = s_q.nbyte + 4'h1;
											s_d.ph    = PH_DATA;
										end
									end
									PH_ADDRR:
									begin
										s_d.rd = 1'b1;
										s_d.ph = PH_DATA;
									end
									PH_DATA:
									begin
										if (s_q.nbyte == s_q.req.count)
											s_d.st = ST_STOP;
										else if (!s_q.rd)
										begin
											s_d.sh    = mem_rd;
											s_d.nbyte = s_q.nbyte + 4'h1;
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			ST_STOP:
			begin
				if (tick)
				begin
					s_d.qtr = s_q.qtr + 2'h1;
					unique case (s_q.qtr)
						2'h0: s_d.pins.sda_oe = 1'b1;
						2'h1: s_d.pins.scl_oe = 1'b0;
						2'h2: s_d.pins.sda_oe = 1'b0;
						2'h3: s_d.st = ST_DONE;
					endcase
				end
			end
			ST_DONE:
			begin
				s_d.done = 1'b1;
				s_d.st   = ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			s_q <= '{st: ST_IDLE, ph: PH_ADDRW, req: '0, pins: '0, default: '0};
		else
			s_q <= s_d;
	end

	assign o_rd_data   = mem_rd;
	assign o_busy      = s_q.st != ST_IDLE;
	assign o_done      = s_q.done;
	assign o_nack      = s_q.nack;
	assign o_bus_owned = sec_ok;
	assign o_status    = {s_q.nbyte, 1'b0, s_q.nack, sec_ok, s_q.st != ST_IDLE};
	assign o_scl_out   = 1'b0;
	assign o_sda_out   = 1'b0;
	assign o_scl_oe    = s_q.pins.scl_oe;
	assign o_sda_oe    = s_q.pins.sda_oe;
	assign o_bus_sel   = s_q.dir[SEL_BIT] & s_q.dat[SEL_BIT];

	a_sel_order: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$rose(s_q.dat[SEL_BIT]) |-> $past(s_q.dir[SEL_BIT]))
		else $error("select data set before direction");
	a_sel_release: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_release_bus && !o_busy) |=> !o_bus_sel)
		else $error("select not released");
	a_sec_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(s_q.st == ST_IDLE && s_d.st == ST_START && s_d.req.sec_bus) |-> o_bus_owned)
		else $error("secondary transfer without ownership");
	a_done_pulse: assert property (@(posedge i_clock) disable iff (!i_nrst)
		o_done |=> !o_done && !o_busy)
		else $error("done not a single pulse");
	a_fmt_index: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_busy && s_q.req.op == ISB_OP_FMT) |-> s_q.req.index == ACCEL_FMT_IDX)
		else $error("format index wrong");
	a_axes_burst: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_busy && s_q.req.op == ISB_OP_AXES) |-> s_q.req.count == 4'(AXIS_BYTES) && s_q.req.index == ACCEL_XLO_IDX)
		else $error("axis burst not six bytes from 0x32");
	a_addr_sel: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(s_q.st == ST_BIT && s_q.ph == PH_ADDRW && s_q.bitn == 3'h7 && !s_q.req.sec_bus && s_q.qtr == 2'h0)
		|-> s_q.sh[7:1] == ACCEL_ADDR)
		else $error("accelerometer address wrong");
	a_vdec_addr: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(s_q.st == ST_BIT && s_q.ph == PH_ADDRW && s_q.bitn == 3'h7 && s_q.req.sec_bus && s_q.qtr == 2'h0)
		|-> s_q.sh[7:1] == VDEC_ADDR)
		else $error("decoder address wrong");
endmodule : isb_master

/* File: rtl/isb_pkg.sv */
/*
 * isb_pkg: constants and carrier types for the sensor i2c master and bus select block.
 * assumes a 10 MHz clock and an open-drain i2c bus with external pull-ups.
 */
package isb_pkg;

	localparam int          CLK_HZ          = 10_000_000;
	localparam int          SCL_HZ          = 100_000;
	localparam int          QTR_CYC         = CLK_HZ / (SCL_HZ * 4);
	localparam logic [6:0]  ACCEL_ADDR      = 7'h53;
	localparam logic [6:0]  VDEC_ADDR       = 7'h20;
	localparam logic [7:0]  ACCEL_FMT_IDX   = 8'h31;
	localparam logic [7:0]  ACCEL_XLO_IDX   = 8'h32;
	localparam logic [31:0] SEL_MASK        = 32'h0008_0000;
	localparam int          SEL_BIT         = 19;
	localparam int          AXIS_BYTES      = 6;
	localparam int          MAX_BYTES       = 8;
	// full resolution, +-16g, left justified
	localparam logic [7:0]  ACCEL_FMT_VAL   = 8'h0f;

	typedef enum logic [1:0]
	{
		ISB_OP_WRITE,
		ISB_OP_READ,
		ISB_OP_FMT,
		ISB_OP_AXES
	} isb_op_t;

	typedef struct packed
	{
		isb_op_t     op;
		logic        sec_bus;
		logic [7:0]  index;
		logic [3:0]  count;
	} isb_req_t;

	typedef struct packed
	{
		logic scl_oe;
		logic sda_oe;
	} isb_pins_t;

endpackage : isb_pkg

/* File: testbench/isb_slave_model.sv */
/* isb_slave_model: i2c slave for the sensor and, behind the select line, the decoder.
   assumes pulled-up bus levels from the bench; it never stretches the clock. */
`timescale 1ns/1ps
module isb_slave_model
(
	// bus levels and select
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_sel,
	// forced nack, data pull-down
	input  wire logic i_mute,
	output logic      o_sda_oe
);
	localparam logic CS_HIGH = 1'b1;
	logic [7:0] mem [512];
	logic [7:0] sh_q, ptr_q;
	logic       act_q = 0, rd_q = 0, adr_q = 0, ix_q = 0, dev_q = 0;
	int         bit_q = 9;
	initial
		o_sda_oe = 0;
	// start and stop; the pointer survives a repeated start
	always @(i_sda)
		if (i_scl)
		begin
			bit_q = i_sda ? 9 : -1;
			adr_q = !i_sda;
			act_q = act_q && !i_sda;
		end
	// read bytes rotate through the shifter, so bit 7 is always next
	always @(posedge i_scl)
		if (bit_q >= 0 && bit_q < 8)
			sh_q = {sh_q[6:0], i_sda};
		else if (bit_q == 8 && rd_q && i_sda)
			act_q = 0;
	always @(negedge i_scl)
	begin
		bit_q = (bit_q == 8) ? 0 : bit_q + 1;
		o_sda_oe = 0;
		if (bit_q == 8 && adr_q)
		begin
			dev_q = sh_q[7:1] == 7'h20;
			act_q = CS_HIGH && !i_mute && (sh_q[7:1] == 7'h53 || (dev_q && i_sel));
			rd_q = sh_q[0];
			ix_q = 1;
			adr_q = 0;
			o_sda_oe = act_q;
		end
		else if (bit_q == 8 && act_q && !rd_q)
		begin
			if (!ix_q)
				mem[{dev_q, ptr_q}] = sh_q;
			ptr_q = ix_q ? sh_q : ptr_q + 1;
			ix_q = 0;
			o_sda_oe = 1;
		end
		else if (bit_q < 8 && act_q && rd_q)
		begin
			if (bit_q == 0)
				sh_q = mem[{dev_q, ptr_q}];
			ptr_q = ptr_q + (bit_q == 7);
			o_sda_oe = !sh_q[7];
		end
	end
endmodule : isb_slave_model

/* File: testbench/tb_top.sv */
/* tb_top: random and corner runs of isb_master against the i2c slave model.
   assumes nothing outside; clock, reset and pull-ups are made here. */
`timescale 1ns/1ps
module tb_top import isb_pkg::*;
;
	logic        clk = 0, nrst = 0, start = 0, take = 0, rel = 0, we = 0, mute = 0;
	logic [2:0]  wa = 0, ra = 0;
	logic [7:0]  wd = 0, idx, rdat, stat, exp [8];
	logic [31:0] rs = 32'hdbf8;
	logic        busy, done, nack, owned, sel, scl_oe, sda_oe, s_oe;
	isb_req_t    req = '0;
	int          failures = 0, cmp_count = 0, n;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe || s_oe);
	isb_master u_dut (.i_clock(clk), .i_nrst(nrst), .i_start(start), .i_req(req), .i_take_bus(take),
		.i_release_bus(rel), .i_wr_we(we), .i_wr_addr(wa), .i_wr_data(wd), .i_rd_addr(ra), .o_rd_data(rdat),
		.o_busy(busy), .o_done(done), .o_nack(nack), .o_bus_owned(owned), .o_status(stat), .i_scl(scl),
		.i_sda(sda), .o_scl_out(), .o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe), .o_bus_sel(sel));
	isb_slave_model u_slv (.i_scl(scl), .i_sda(sda), .i_sel(sel), .i_mute(mute), .o_sda_oe(s_oe));
	always #50 clk = !clk;
	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction : rnd
	// full resolution, left justified, 16g range
	function automatic logic [7:0] fmt_exp();
		return {4'h0, 1'b1, 1'b1, 2'b11};
	endfunction : fmt_exp
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] ex);
		cmp_count++;
		if (got !== ex)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1;
		@(negedge clk);
		s = 0;
	endtask : pulse
	task automatic kick(input isb_op_t op, input logic sec, input logic [7:0] ix, input logic [3:0] cnt);
		req = '{op, sec, ix, cnt};
		pulse(start);
	endtask : kick
	// bounded wait: a lost done pulse must not hang the run
	task automatic run(input isb_op_t op, input logic sec, input logic [7:0] ix, input logic [3:0] cnt);
		int t;
		kick(op, sec, ix, cnt);
		for (t = 0; t < 20000 && done !== 1'b1; t++)
			@(negedge clk);
		if (t == 20000)
			failures++;
	endtask : run
	task automatic ld(input int cnt);
		for (int i = 0; i < cnt; i++)
		begin
			@(negedge clk);
			we = 1;
			wa = i[2:0];
			wd = exp[i];
		end
		@(negedge clk);
		we = 0;
	endtask : ld
	task automatic rb(input int cnt);
		for (int i = 0; i < cnt; i++)
		begin
			@(negedge clk);
			ra = i[2:0];
			@(negedge clk);
			chk("rd_data", rdat, exp[i]);
		end
	endtask : rb
	initial
	begin
		repeat (8) @(negedge clk);
		chk("sel", {7'h0, sel}, 8'h00);
		nrst = 1;
		run(ISB_OP_FMT, 1'b0, 8'h00, 4'h0);
		chk("fmt", u_slv.mem[9'h031], fmt_exp());
		$display("format test done");
		for (int k = 0; k < 3; k++)
		begin
			n = (k == 0) ? 8 : rnd() % 4 + 1;
			idx = rnd() & 8'h7f;
			for (int i = 0; i < n; i++)
				exp[i] = rnd();
			ld(n);
			run(ISB_OP_WRITE, 1'b0, idx, n[3:0]);
			for (int i = 0; i < n; i++)
				chk("mem", u_slv.mem[9'(idx) + 9'(i)], exp[i]);
			run(ISB_OP_READ, 1'b0, idx, n[3:0]);
			rb(n);
		end
		$display("burst test done");
		for (int i = 0; i < 6; i++)
		begin
			exp[i] = rnd();
			u_slv.mem[9'h032 + 9'(i)] = exp[i];
		end
		run(ISB_OP_AXES, 1'b0, 8'h00, 4'h0);
		rb(6);
		$display("axes test done");
		kick(ISB_OP_WRITE, 1'b1, 8'h00, 4'h1);
		chk("busy", {7'h0, busy}, 8'h00);
		pulse(take);
		chk("sel", {7'h0, sel}, 8'h00);
		repeat (2) @(negedge clk);
		chk("sel", {7'h0, sel}, 8'h01);
		chk("owned", {7'h0, owned}, 8'h01);
		exp[0] = rnd();
		exp[1] = rnd();
		ld(2);
		run(ISB_OP_WRITE, 1'b1, 8'h11, 4'h2);
		chk("dec", u_slv.mem[9'h111], exp[0]);
		chk("dec", u_slv.mem[9'h112], exp[1]);
		chk("status", stat, 8'h22);
		run(ISB_OP_READ, 1'b1, 8'h11, 4'h2);
		rb(2);
		pulse(rel);
		repeat (2) @(negedge clk);
		chk("sel", {7'h0, sel}, 8'h00);
		kick(ISB_OP_WRITE, 1'b1, 8'h00, 4'h1);
		chk("busy", {7'h0, busy}, 8'h00);
		mute = 1;
		ld(1);
		run(ISB_OP_WRITE, 1'b0, 8'h00, 4'h1);
		chk("nack", {7'h0, nack}, 8'h01);
		mute = 0;
		run(ISB_OP_FMT, 1'b0, 8'h00, 4'h0);
		chk("nack", {7'h0, nack}, 8'h00);
		$display("switch and nack test done");
		wrap_up();
	end
	initial
	begin
		repeat (95000) @(posedge clk);
		failures++;
		wrap_up();
	end
endmodule : tb_top
